/* File: verilog/ahs_conv.sv */
// ASCII-to-hex converter and linear scaling unit behind an AXI4-Lite slave
// Assumes one clock, synchronous active-low reset, one master
// Contract
// - Map 30-39 and 41-46 to digits
// - Top character bit is parity, not value
// - No parity: top bit must be zero
// - Even/odd parity counts all one bits
// - Parity failure sets error, no write
// - Bad digit control or area sets error
// - Missing indirect operand sets error
// - Scale on execution, else do nothing
// - Round scaled result to nearest integer
// - Result is By minus slope times (Bx-S)
// - Equal X points set error, no result
// - Non-BCD Y or area fault sets error
// - Equal flag set when result is zero
// - Convert 1-4 bytes into digits in order
// - Wrap destination digits, keep the rest
// - Parity code 0 none, 1 even, 2 odd
`include "ahs_map.svh"
module ahs_conv
  import ahs_pkg::*;
#(
  parameter int AW = 8
) (
  input wire logic i_clk, // Clock
  input wire logic i_rst_n, // Sync reset
  input wire logic [AW-1:0] i_awaddr, // Write address
  input wire logic i_awvalid, // Write address valid
  output logic o_awready, // Write address ready
  input wire logic [31:0] i_wdata, // Write data
  input wire logic [3:0] i_wstrb, // Byte enables
  input wire logic i_wvalid, // Write data valid
  output logic o_wready, // Write data ready
  output logic [1:0] o_bresp, // Write response
  output logic o_bvalid, // Response valid
  input wire logic i_bready, // Response ready
  input wire logic [AW-1:0] i_araddr, // Read address
  input wire logic i_arvalid, // Read address valid
  output logic o_arready, // Read address ready
  output logic [31:0] o_rdata, // Read data
  output logic [1:0] o_rresp, // Read response
  output logic o_rvalid, // Read data valid
  input wire logic i_rready, // Read ready
  output logic o_irq // Level interrupt
);
  if (AW < 8)
  begin : g_chk
    $error("AW must be at least 8");
  end

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= `AHS_OFF_IEN);
  endfunction : mapped

  function automatic logic bcd_ok(input logic [15:0] b);
    return (b[15:12] < 4'ha) && (b[11:8] < 4'ha) && (b[7:4] < 4'ha) && (b[3:0] < 4'ha);
  endfunction : bcd_ok

  function automatic logic [13:0] bcd2bin(input logic [15:0] b);
    return 14'({10'h0, b[15:12]} * 14'h3e8 + {10'h0, b[11:8]} * 14'h64
      + {10'h0, b[7:4]} * 14'ha + {10'h0, b[3:0]});
  endfunction : bcd2bin

  function automatic logic [15:0] bin2bcd(input logic [13:0] b);
    logic [29:0] s;
    s = {16'h0, b};
    for (int i = 0; i < 14; i++)
    begin
      for (int j = 0; j < 4; j++)
        if (s[14+4*j +: 4] > 4'h4) s[14+4*j +: 4] = s[14+4*j +: 4] + 4'h3;
      s = s << 1;
    end
    return s[29:14];
  endfunction : bin2bcd

  logic awrdy_r, wrdy_r, bvalid_r, ardy_r, rvalid_r, irq_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r, rd_word;
  logic [7:0] wa_r;
  logic [31:0] wd_r;
  logic [3:0] ws_r;
  logic [1:0] fault_r, ist_r, ien_r;
  logic [15:0] dcw_r, dest_r, rslt_r;
  logic [15:0] src_r [3];
  ahs_pts_t pts_r;
  ahs_flags_t flags_r;
  ahs_state_t st_r;
  logic [33:0] nq_r;
  logic [16:0] rem_r, den_r;
  logic [13:0] by_r;
  logic neg_r;
  logic [5:0] cnt_r;

  // Bus write is performed once address and data are both held
  wire wr_do = !awrdy_r && !wrdy_r && !bvalid_r;
  wire [15:0] wd16 = {ws_r[1] ? wd_r[15:8] : 8'h00, ws_r[0] ? wd_r[7:0] : 8'h00};
  wire [15:0] wm16 = {{8{ws_r[1]}}, {8{ws_r[0]}}};
  wire sel_ctrl = wr_do && wa_r == `AHS_OFF_CTRL && ws_r[0];
  wire idle = st_r == ST_IDLE;
  wire hex_go = sel_ctrl && wd_r[`AHS_CTRL_HEX] && idle;
  wire scl_go = sel_ctrl && wd_r[`AHS_CTRL_SCL] && idle && !wd_r[`AHS_CTRL_HEX];
  // Fault bits of the starting write apply to that same execution
  wire ptr_bad = wd_r[`AHS_CTRL_PTR];
  wire area_bad = wd_r[`AHS_CTRL_AREA];

  // ASCII conversion, evaluated in the starting cycle
  wire [3:0] fd = dcw_r[3:0];
  wire [3:0] nb = dcw_r[7:4];
  wire [3:0] fb = dcw_r[11:8];
  wire [3:0] pm = dcw_r[15:12];
  wire dcw_bad = fd > 4'h3 || nb > 4'h3 || fb > 4'h1 || pm > `AHS_PAR_ODD;
  wire [47:0] sbytes = {src_r[2], src_r[1], src_r[0]};
  logic [15:0] hx_dst;
  logic hx_bad;
  always_comb
  begin
    logic [7:0] ch;
    logic [3:0] d;
    logic [1:0] p;
    ch = 8'h00;
    d = 4'h0;
    p = 2'h0;
    hx_dst = dest_r;
    hx_bad = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      if (i <= int'(nb[1:0]))
      begin
        ch = sbytes[8*(i+int'(fb[0])) +: 8];
        if (pm == `AHS_PAR_NONE && ch[7]) hx_bad = 1'b1;
        if (pm == `AHS_PAR_EVEN && ^ch) hx_bad = 1'b1;
        if (pm == `AHS_PAR_ODD && !(^ch)) hx_bad = 1'b1;
        if (ch[6:0] >= 7'h30 && ch[6:0] <= 7'h39) d = ch[3:0];
        else if ((ch[6:0] >= 7'h41 && ch[6:0] <= 7'h46) || (ch[6:0] >= 7'h61 && ch[6:0] <= 7'h66))
          d = ch[3:0] + 4'h9;
        else hx_bad = 1'b1;
        p = fd[1:0] + 2'(i);
        hx_dst[4*p +: 4] = d;
      end
    end
  end
  wire hx_err = dcw_bad || hx_bad || ptr_bad || area_bad;

  // Scaling setup: slope numerator and divisor magnitudes
  wire [13:0] ayb = bcd2bin(pts_r.ay);
  wire [13:0] byb = bcd2bin(pts_r.by);
  wire sc_err = !bcd_ok(pts_r.ay) || !bcd_ok(pts_r.by) || ptr_bad || area_bad
    || pts_r.ax == pts_r.bx;
  wire signed [14:0] dy = $signed({1'b0, byb}) - $signed({1'b0, ayb});
  wire signed [16:0] dx = $signed({1'b0, pts_r.bx}) - $signed({1'b0, pts_r.ax});
  wire signed [16:0] dn = $signed({1'b0, pts_r.bx}) - $signed({1'b0, src_r[0]});
  wire signed [31:0] num = dy * dn;
  wire [31:0] anum = num[31] ? 32'(-num) : 32'(num);
  wire [15:0] adx = dx[16] ? 16'(-dx) : 16'(dx);
  // Adding half the divisor rounds the magnitude to nearest
  wire [33:0] numer = {1'b0, anum, 1'b0} + {18'h0, adx};

  // One restoring divider step per cycle
  wire [17:0] rs = {rem_r, nq_r[33]};
  wire ge = rs >= {1'b0, den_r};
  wire [17:0] rsub = rs - {1'b0, den_r};
  wire signed [35:0] q = $signed({2'h0, nq_r});
  wire signed [35:0] sres = $signed({22'h0, by_r}) + (neg_r ? q : -q);
  wire [13:0] clamped = sres < 0 ? 14'h0 : (sres > $signed({22'h0, `AHS_BCD_MAX}))
    ? `AHS_BCD_MAX : sres[13:0];
  wire [15:0] sc_bcd = bin2bcd(clamped);

  wire ev_done = (hex_go && !hx_err) || st_r == ST_FIN;
  wire ev_err = (hex_go && hx_err) || (scl_go && sc_err);
  wire [1:0] iclr = (wr_do && wa_r == `AHS_OFF_ICLR && ws_r[0]) ? wd_r[1:0] : 2'h0;
  wire [1:0] ev = {ev_err, ev_done};

  wire [7:0] rd_a = i_araddr[7:0];
  always_comb
  begin
    rd_word = 32'h0;
    if (rd_a == `AHS_OFF_CTRL) rd_word = {28'h0, fault_r, 2'h0};
    else if (rd_a == `AHS_OFF_DCW) rd_word = {16'h0, dcw_r};
    else if (rd_a == `AHS_OFF_SRC0) rd_word = {16'h0, src_r[0]};
    else if (rd_a == `AHS_OFF_SRC1) rd_word = {16'h0, src_r[1]};
    else if (rd_a == `AHS_OFF_SRC2) rd_word = {16'h0, src_r[2]};
    else if (rd_a == `AHS_OFF_PAY) rd_word = {16'h0, pts_r.ay};
    else if (rd_a == `AHS_OFF_PAX) rd_word = {16'h0, pts_r.ax};
    else if (rd_a == `AHS_OFF_PBY) rd_word = {16'h0, pts_r.by};
    else if (rd_a == `AHS_OFF_PBX) rd_word = {16'h0, pts_r.bx};
    else if (rd_a == `AHS_OFF_DEST) rd_word = {16'h0, dest_r};
    else if (rd_a == `AHS_OFF_RSLT) rd_word = {16'h0, rslt_r};
    else if (rd_a == `AHS_OFF_FLAG) rd_word = {29'h0, flags_r};
    else if (rd_a == `AHS_OFF_IST) rd_word = {30'h0, ist_r};
    else if (rd_a == `AHS_OFF_IEN) rd_word = {30'h0, ien_r};
  end

  // Bus handshakes
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      {awrdy_r, wrdy_r, ardy_r} <= 3'h7;
      {bvalid_r, rvalid_r} <= 2'h0;
      {bresp_r, rresp_r} <= 4'h0;
      rdata_r <= 32'h0;
      wa_r <= 8'h0;
      wd_r <= 32'h0;
      ws_r <= 4'h0;
    end
    else
    begin
      if (i_awvalid && awrdy_r) {awrdy_r, wa_r} <= {1'b0, i_awaddr[7:0]};
      if (i_wvalid && wrdy_r) {wrdy_r, wd_r, ws_r} <= {1'b0, i_wdata, i_wstrb};
      if (wr_do) {bvalid_r, bresp_r} <= {1'b1, mapped(wa_r) ? `AHS_RESP_OK : `AHS_RESP_ERR};
      if (bvalid_r && i_bready) {bvalid_r, awrdy_r, wrdy_r} <= 3'h3;
      if (i_arvalid && ardy_r)
      begin
        {ardy_r, rvalid_r, rdata_r} <= {2'h1, rd_word};
        rresp_r <= mapped(rd_a) ? `AHS_RESP_OK : `AHS_RESP_ERR;
      end
      if (rvalid_r && i_rready) {rvalid_r, ardy_r} <= 2'h1;
    end
  end

  // Software-written words
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      {dcw_r, src_r[0], src_r[1], src_r[2]} <= {4{`AHS_RST_WORD}};
      pts_r <= {4{`AHS_RST_WORD}};
      {fault_r, ien_r} <= 4'h0;
    end
    else if (wr_do)
    begin
      if (wa_r == `AHS_OFF_CTRL && ws_r[0]) fault_r <= wd_r[3:2];
      else if (wa_r == `AHS_OFF_DCW) dcw_r <= (dcw_r & ~wm16) | wd16;
      else if (wa_r == `AHS_OFF_SRC0) src_r[0] <= (src_r[0] & ~wm16) | wd16;
      else if (wa_r == `AHS_OFF_SRC1) src_r[1] <= (src_r[1] & ~wm16) | wd16;
      else if (wa_r == `AHS_OFF_SRC2) src_r[2] <= (src_r[2] & ~wm16) | wd16;
      else if (wa_r == `AHS_OFF_PAY) pts_r.ay <= (pts_r.ay & ~wm16) | wd16;
      else if (wa_r == `AHS_OFF_PAX) pts_r.ax <= (pts_r.ax & ~wm16) | wd16;
      else if (wa_r == `AHS_OFF_PBY) pts_r.by <= (pts_r.by & ~wm16) | wd16;
      else if (wa_r == `AHS_OFF_PBX) pts_r.bx <= (pts_r.bx & ~wm16) | wd16;
      else if (wa_r == `AHS_OFF_IEN && ws_r[0]) ien_r <= wd_r[1:0];
    end
  end

  // Destination word: bus write or conversion result
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n) dest_r <= `AHS_RST_WORD;
    else if (hex_go && !hx_err) dest_r <= hx_dst;
    else if (wr_do && wa_r == `AHS_OFF_DEST) dest_r <= (dest_r & ~wm16) | wd16;
  end

  // Scaling sequencer and flags
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      st_r <= ST_IDLE;
      flags_r <= '0;
      rslt_r <= `AHS_RST_WORD;
      {nq_r, rem_r, den_r, by_r, neg_r, cnt_r} <= '0;
    end
    else
    begin
      case (st_r)
        ST_IDLE:
          if (hex_go) flags_r.err <= hx_err;
          else if (scl_go && sc_err) flags_r.err <= 1'b1;
          else if (scl_go)
          begin
            st_r <= ST_DIV;
            flags_r.busy <= 1'b1;
            {nq_r, rem_r, den_r} <= {numer, 17'h0, adx, 1'b0};
            {by_r, neg_r, cnt_r} <= {byb, num[31] ^ dx[16], 6'h0};
          end
        ST_DIV:
        begin
          nq_r <= {nq_r[32:0], ge};
          rem_r <= ge ? rsub[16:0] : rs[16:0];
          cnt_r <= cnt_r + 6'h1;
          if (cnt_r == `AHS_DIV_STEPS - 6'h1) st_r <= ST_FIN;
        end
        ST_FIN:
        begin
          st_r <= ST_IDLE;
          rslt_r <= sc_bcd;
          flags_r <= '{busy: 1'b0, equal: sc_bcd == 16'h0, err: 1'b0};
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Interrupt status: set wins over clear
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n) {ist_r, irq_r} <= 3'h0;
    else
    begin
      ist_r <= (ist_r & ~iclr) | ev;
      irq_r <= |(ist_r & ien_r);
    end
  end

  assign o_awready = awrdy_r;
  assign o_wready = wrdy_r;
  assign o_bvalid = bvalid_r;
  assign o_bresp = bresp_r;
  assign o_arready = ardy_r;
  assign o_rvalid = rvalid_r;
  assign o_rdata = rdata_r;
  assign o_rresp = rresp_r;
  assign o_irq = irq_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  parity_err_a: assert property (hex_go && hx_bad |=> flags_r.err
    && dest_r == $past(dest_r)) else $error("parity fault did not block write");
  hex_write_a: assert property (hex_go && !hx_err |=> dest_r == $past(hx_dst)
    && !flags_r.err) else $error("hex result not written");
  bad_dcw_a: assert property (hex_go && dcw_bad |=> flags_r.err)
    else $error("bad digit control not flagged");
  x_equal_a: assert property (scl_go && pts_r.ax == pts_r.bx |=> flags_r.err
    && idle && $stable(rslt_r)) else $error("equal X points not refused");
  bcd_param_a: assert property (scl_go && !bcd_ok(pts_r.by) |=> flags_r.err)
    else $error("non-BCD Y point not flagged");
  scl_len_a: assert property (scl_go && !sc_err |-> ##35 st_r == ST_FIN)
    else $error("scaling length wrong");
  no_exec_a: assert property (idle && !scl_go |=> $stable(rslt_r))
    else $error("result changed without execution");
  clamp_rng_a: assert property (bcd_ok(rslt_r) && rslt_r <= 16'h9999)
    else $error("result out of range");
  equal_zero_a: assert property (st_r == ST_FIN |=> flags_r.equal == (rslt_r == 16'h0))
    else $error("equal flag wrong");
  irq_lvl_a: assert property (|(ist_r & ien_r) |=> o_irq)
    else $error("interrupt not raised");

  hex_ok_c: cover property (hex_go && !hx_err && nb[1:0] == 2'h3);
  scl_ok_c: cover property (st_r == ST_FIN && sc_bcd != 16'h0);
  clamp_hi_c: cover property (st_r == ST_FIN && clamped == `AHS_BCD_MAX);
  par_err_c: cover property (hex_go && hx_bad && pm == `AHS_PAR_ODD);
endmodule : ahs_conv

/* File: verilog/ahs_map.svh */
// Register map, field positions, reset values and counts of the conversion unit
// Assumes a 32-bit AXI4-Lite slave with 8 address bits decoded
`ifndef AHS_MAP_SVH
`define AHS_MAP_SVH
`define AHS_OFF_CTRL 8'h00
`define AHS_OFF_DCW 8'h04
`define AHS_OFF_SRC0 8'h08
`define AHS_OFF_SRC1 8'h0c
`define AHS_OFF_SRC2 8'h10
`define AHS_OFF_PAY 8'h14
`define AHS_OFF_PAX 8'h18
`define AHS_OFF_PBY 8'h1c
`define AHS_OFF_PBX 8'h20
`define AHS_OFF_DEST 8'h24
`define AHS_OFF_RSLT 8'h28
`define AHS_OFF_FLAG 8'h2c
`define AHS_OFF_IST 8'h30
`define AHS_OFF_ICLR 8'h34
`define AHS_OFF_IEN 8'h38
`define AHS_CTRL_HEX 0
`define AHS_CTRL_SCL 1
`define AHS_CTRL_PTR 2
`define AHS_CTRL_AREA 3
`define AHS_INT_DONE 0
`define AHS_INT_ERR 1
`define AHS_PAR_NONE 4'h0
`define AHS_PAR_EVEN 4'h1
`define AHS_PAR_ODD 4'h2
`define AHS_RST_WORD 16'h0000
`define AHS_BCD_MAX 14'h270f
`define AHS_DIV_STEPS 6'h22
`define AHS_RESP_OK 2'h0
`define AHS_RESP_ERR 2'h2
`endif

/* File: verilog/ahs_pkg.sv */
// Types shared by the conversion unit
// Assumes ahs_map.svh holds all numeric constants
package ahs_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_FIN} ahs_state_t;
  typedef struct packed {
    logic busy;
    logic equal;
    logic err;
  } ahs_flags_t;
  typedef struct packed {
    logic [15:0] ay;
    logic [15:0] ax;
    logic [15:0] by;
    logic [15:0] bx;
  } ahs_pts_t;
endpackage : ahs_pkg

/* File: bench/ahs_conv_tb.sv */
// Self-checking bench for the conversion unit, driven over AXI4-Lite
// Assumes ahs_conv with its register map header and one 125 MHz clock
`include "ahs_map.svh"
`define CHK(a, b) \
  begin \
    checked++; \
    if ((a) !== (b)) \
    begin \
      errors++; \
      $display("wrong value t=%0t got %h exp %h", $time, (a), (b)); \
    end \
  end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk, i_rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int errors, checked, cyc;
  ahs_conv u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .o_irq(irq));
  initial
  begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  task automatic test_done();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  // Watchdog: a hung handshake ends the run as a failure
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      errors++;
      test_done();
    end
  end
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa;
    logic pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge i_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pa || pw)
    begin
      @(posedge i_clk);
      if (pa && awready === 1'b1)
      begin
        pa = 1'b0;
        awvalid <= 1'b0;
      end
      if (pw && wready === 1'b1)
      begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge i_clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge i_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge i_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge i_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axr
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    axr(a, d, r);
  endtask : rd
  task automatic t_digits();
    logic [31:0] d;
    for (int i = 0; i < 16; i++)
    begin
      wr(`AHS_OFF_DCW, 32'h0);
      wr(`AHS_OFF_SRC0, (i < 10) ? 32'h30 + i : 32'h37 + i);
      wr(`AHS_OFF_CTRL, 32'h1);
      rd(`AHS_OFF_DEST, d);
      `CHK(d[3:0], i[3:0])
    end
  endtask : t_digits
  task automatic t_wrap();
    logic [31:0] d;
    wr(`AHS_OFF_DEST, 32'habcd);
    wr(`AHS_OFF_SRC0, 32'h3130);
    wr(`AHS_OFF_SRC1, 32'h4232);
    wr(`AHS_OFF_DCW, 32'h0123);
    wr(`AHS_OFF_CTRL, 32'h1);
    rd(`AHS_OFF_DEST, d);
    `CHK(d[15:0], 16'h1bb2)
  endtask : t_wrap
  task automatic t_parity();
    logic [15:0] pd [6] = '{16'h1000, 16'h2000, 16'h2000, 16'h0000, 16'h1000, 16'h0000};
    logic [7:0] ps [6] = '{8'hb1, 8'hb1, 8'h32, 8'hb3, 8'h34, 8'h35};
    logic pe [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [3:0] px [6] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h2, 4'h5};
    logic [31:0] d;
    wr(`AHS_OFF_DEST, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      wr(`AHS_OFF_DCW, {16'h0, pd[i]});
      wr(`AHS_OFF_SRC0, {24'h0, ps[i]});
      wr(`AHS_OFF_CTRL, 32'h1);
      rd(`AHS_OFF_FLAG, d);
      `CHK(d[0], pe[i])
      rd(`AHS_OFF_DEST, d);
      `CHK(d[15:0], {12'h0, px[i]})
    end
  endtask : t_parity
  task automatic t_fault();
    logic [31:0] d;
    wr(`AHS_OFF_DCW, 32'h0004);
    wr(`AHS_OFF_SRC0, 32'h36);
    wr(`AHS_OFF_CTRL, 32'h1);
    rd(`AHS_OFF_FLAG, d);
    `CHK(d[0], 1'b1)
    wr(`AHS_OFF_DCW, 32'h0);
    wr(`AHS_OFF_CTRL, 32'h9);
    rd(`AHS_OFF_FLAG, d);
    `CHK(d[0], 1'b1)
    rd(`AHS_OFF_DEST, d);
    `CHK(d[15:0], 16'h0005)
    wr(`AHS_OFF_CTRL, 32'h1);
    rd(`AHS_OFF_DEST, d);
    `CHK(d[15:0], 16'h0006)
  endtask : t_fault
  // Loads the four points and the source, starts, and waits out busy
  task automatic scl(input logic [15:0] ay, ax, by, bx, s, input logic [3:0] c,
    output logic [31:0] f, output logic [31:0] q);
    wr(`AHS_OFF_PAY, {16'h0, ay});
    wr(`AHS_OFF_PAX, {16'h0, ax});
    wr(`AHS_OFF_PBY, {16'h0, by});
    wr(`AHS_OFF_PBX, {16'h0, bx});
    wr(`AHS_OFF_SRC0, {16'h0, s});
    wr(`AHS_OFF_CTRL, {28'h0, c});
    for (int i = 0; i < 60; i++)
    begin
      rd(`AHS_OFF_FLAG, f);
      if (f[2] === 1'b0)
        break;
    end
    `CHK(f[2], 1'b0)
    rd(`AHS_OFF_RSLT, q);
  endtask : scl
  task automatic t_scale();
    logic [31:0] f, q;
    scl(16'h0010, 16'h0005, 16'h0050, 16'h0019, 16'h0100, 4'h2, f, q);
    `CHK({q[15:0], f[2:0]}, {16'h0512, 3'h0})
    scl(16'h0000, 16'h0000, 16'h0001, 16'h0003, 16'h0002, 4'h2, f, q);
    `CHK(q[15:0], 16'h0001)
    scl(16'h0000, 16'h0010, 16'h0010, 16'h0020, 16'h0000, 4'h2, f, q);
    `CHK({q[15:0], f[1:0]}, {16'h0000, 2'h2})
    scl(16'h0010, 16'h0005, 16'h0050, 16'h0019, 16'hffff, 4'h2, f, q);
    `CHK({q[15:0], f[1:0]}, {16'h9999, 2'h0})
  endtask : t_scale
  task automatic t_scale_err();
    logic [31:0] f, q;
    scl(16'h0010, 16'h0005, 16'h0050, 16'h0005, 16'h0100, 4'h2, f, q);
    `CHK({q[15:0], f[0]}, {16'h9999, 1'b1})
    scl(16'h00a0, 16'h0005, 16'h0050, 16'h0019, 16'h0100, 4'h2, f, q);
    `CHK({q[15:0], f[0]}, {16'h9999, 1'b1})
    scl(16'h0010, 16'h0005, 16'h0050, 16'h0019, 16'h0100, 4'h6, f, q);
    `CHK({q[15:0], f[0]}, {16'h9999, 1'b1})
  endtask : t_scale_err
  task automatic t_irq();
    logic [31:0] d;
    wr(`AHS_OFF_IEN, 32'h0);
    wr(`AHS_OFF_ICLR, 32'h3);
    wr(`AHS_OFF_DCW, 32'h0004);
    wr(`AHS_OFF_CTRL, 32'h1);
    rd(`AHS_OFF_IST, d);
    `CHK(d[1], 1'b1)
    `CHK(irq, 1'b0)
    wr(`AHS_OFF_IEN, 32'h2);
    repeat (2) @(posedge i_clk);
    `CHK(irq, 1'b1)
    wr(`AHS_OFF_ICLR, 32'h3);
    repeat (2) @(posedge i_clk);
    `CHK(irq, 1'b0)
  endtask : t_irq
  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0] r;
    axw(8'h3c, 32'h1234, r);
    `CHK(r, `AHS_RESP_ERR)
    axr(8'h40, d, r);
    `CHK(r, `AHS_RESP_ERR)
    rd(`AHS_OFF_DEST, d);
    `CHK(d[15:0], 16'h0006)
  endtask : t_unmapped
  initial
  begin
    i_rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    errors = 0;
    checked = 0;
    cyc = 0;
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_digits();
    t_wrap();
    t_parity();
    t_fault();
    t_scale();
    t_scale_err();
    t_unmapped();
    t_irq();
    test_done();
  end
endmodule : testbench
